// ---- hdl/bap_consts.svh ----
// bap_consts.svh: register indices, field positions, reset values, timing
// assumes: included by bare name; byte address = 4 * index
`ifndef BAP_CONSTS_SVH
`define BAP_CONSTS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define BAP_IDX_MISC6     8'h70
`define BAP_IDX_FORCE_CTL 8'h74
`define BAP_IDX_ACT_MASK  8'h75
`define BAP_IDX_SMI_EN    8'h82
`define BAP_IDX_S2S_TMR   8'h86
`define BAP_IDX_REQ_CLR   8'hA2
`define BAP_IDX_MODE_STS  8'hA4
`define BAP_IDX_SRC_STS   8'hA5
`define BAP_IDX_PMU_CTL3  8'hAD

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BAP_BIT_SOFT_PWR    5
`define BAP_BIT_FORCE_DIS   7
`define BAP_BIT_PWR_MASK    6
`define BAP_BIT_PWR_ACT_EN  4
`define BAP_BIT_EN_RESUME   0
`define BAP_BIT_EN_LOW_DOZE 1
`define BAP_BIT_EN_DOZE_SLP 2
`define BAP_BIT_EN_SLP_SUS  3
`define BAP_SRC_RESUME      0
`define BAP_SRC_SLP_SUS     3

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define BAP_RST_BYTE     8'h00
`define BAP_CLK_NS       10
`define BAP_REFRESH_NS   15000
`define BAP_REFRESH_CYC  (`BAP_REFRESH_NS / `BAP_CLK_NS)

`endif

// ---- hdl/bap_pkg.sv ----
// bap_pkg.sv: types of the power manager event block
// assumes: nothing
package bap_pkg;

  // one-hot power modes, highest to lowest
  typedef enum logic [5:0] {
    PM_HIGH    = 6'h01,
    PM_LOW     = 6'h02,
    PM_DOZE    = 6'h04,
    PM_SLEEP   = 6'h08,
    PM_SUSPEND = 6'h10,
    PM_OFF     = 6'h20
  } bap_mode_t;

endpackage

// ---- hdl/bap_pmu.sv ----
// bap_pmu.sv: battery, external power and suspend key event logic
// assumes: Avalon-MM master, external mode timers give expiry levels
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`include "bap_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: final battery level never SMI, never readable
// R2: final battery low without power forces Suspend
// R3: forced descent steps one mode per refresh
// R4: wake goes high speed, then descends again
// R5: enabled mode-change events pause forced descent
// R6: final battery low in Sleep forces Suspend
// R7: power present inhibits three upper timers
// R8: soft power bit acts like pin, except forcing
// R9: power rising edge makes enabled activity event
// R10: suspend key steps down to Sleep
// R11: resume key jumps to high speed
// R12: resume key raises enabled SMI
// R13: Sleep-to-Suspend expiry raises enabled SMI
// R14: suspend key edge raises no SMI
// R15: source-status write ends Temporary-On into Suspend
// R16: SMI sets source bit, write clears it
// R17: key edge in Temporary-On held until write
// R18: Temporary-On runs clocks, not a mode value
// R19: key ignored until descent reaches Sleep
// R20: SMI level held until request-clear write
// R21: resume enters full-on, not Temporary-On
// R22: refresh strobe paces steps, inputs synchronised
module bap_pmu (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        battery_level_final_n_i,
  input  wire logic        external_power_present_i,
  input  wire logic        suspend_resume_key_i,
  input  wire logic        wake_event_i,
  input  wire logic        tmr_high_low_i,
  input  wire logic        tmr_low_doze_i,
  input  wire logic        tmr_doze_sleep_i,
  input  wire logic        tmr_susp_off_i,
  output logic             smi_request_o,
  output logic             clocks_on_o,
  output logic [5:0]       pm_mode_o,
  output logic             temp_on_o,
  output logic             refresh_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bap_pkg::bap_mode_t mode_r;
  bap_pkg::bap_mode_t step_mode;
  logic [10:0] ref_cnt_r;
  logic        refresh_r;
  logic [1:0]  bl_s_r;
  logic [1:0]  ext_s_r;
  logic [2:0]  key_s_r;
  logic        pwr_d_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [7:0]  misc6_r;
  logic [7:0]  force_ctl_r;
  logic [7:0]  act_mask_r;
  logic [7:0]  smi_en_r;
  logic [7:0]  s2s_tmr_r;
  logic [7:0]  ctl3_r;
  logic [7:0]  s2s_cnt_r;
  logic [7:0]  src_r;
  logic        smi_r;
  logic        temp_on_r;
  logic        susp_go_r;
  logic        key_held_r;
  logic        desc_r;
  logic        resume_pend_r;
  logic        wake_pend_r;
  logic        hit;
  logic        wr_en;
  logic [7:0]  idx;
  logic        a2_wr;
  logic        a5_wr;
  logic        bl_low;
  logic        ext_on;
  logic        pwr_any;
  logic        run_mode;
  logic        force_on;
  logic        pause;
  logic        force_step;
  logic        key_edge;
  logic        key_act;
  logic        act_evt;
  logic        s2s_exp;
  logic        s2s_fire;
  logic        resume_fire;
  logic        busy;
  logic [7:0]  src_set;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // refresh strobe and input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_cnt_r <= 11'h000;
      refresh_r <= 1'b0;
    end
    else
    begin
      refresh_r <= (ref_cnt_r == 11'(`BAP_REFRESH_CYC - 1)); // R22
      if (ref_cnt_r == 11'(`BAP_REFRESH_CYC - 1))
        ref_cnt_r <= 11'h000;
      else
        ref_cnt_r <= ref_cnt_r + 11'h001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bl_s_r  <= 2'h3;
      ext_s_r <= 2'h0;
      key_s_r <= 3'h0;
      pwr_d_r <= 1'b0;
    end
    else
    begin
      bl_s_r  <= {bl_s_r[0], battery_level_final_n_i}; // R22
      ext_s_r <= {ext_s_r[0], external_power_present_i};
      key_s_r <= {key_s_r[1:0], suspend_resume_key_i};
      pwr_d_r <= pwr_any;
    end
  end

  assign bl_low   = ~bl_s_r[1];
  assign ext_on   = ext_s_r[1];
  assign key_edge = key_s_r[1] & ~key_s_r[2];
  assign pwr_any  = ext_on | misc6_r[`BAP_BIT_SOFT_PWR]; // R8
  assign act_evt  = pwr_any & ~pwr_d_r & ctl3_r[`BAP_BIT_PWR_ACT_EN]
                    & ~act_mask_r[`BAP_BIT_PWR_MASK]; // R9

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then completion
  // ----------------------------------------------------------------
  assign hit               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = hit & ~ack_r;
  assign wr_en             = avs_write_i & ack_r;
  assign idx               = avs_address_i[9:2];
  assign a2_wr = wr_en & (idx == `BAP_IDX_REQ_CLR) & (avs_address_i[1:0] == 2'h0);
  assign a5_wr = wr_en & (idx == `BAP_IDX_SRC_STS) & (avs_address_i[1:0] == 2'h0);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    // final battery level has no readable location
    if (avs_address_i[1:0] == 2'h0) // R1
    begin
      case (idx)
        `BAP_IDX_MISC6:     rd_mux[7:0] = misc6_r;
        `BAP_IDX_FORCE_CTL: rd_mux[7:0] = force_ctl_r;
        `BAP_IDX_ACT_MASK:  rd_mux[7:0] = act_mask_r;
        `BAP_IDX_SMI_EN:    rd_mux[7:0] = smi_en_r;
        `BAP_IDX_S2S_TMR:   rd_mux[7:0] = s2s_tmr_r;
        `BAP_IDX_PMU_CTL3:  rd_mux[7:0] = ctl3_r;
        `BAP_IDX_MODE_STS:  rd_mux[5:0] = mode_r; // R18
        `BAP_IDX_SRC_STS:   rd_mux[7:0] = src_r;
        default:            rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= hit & ~ack_r;
      if (avs_read_i & ~ack_r)
        rdata_r <= rd_mux;
    end
  end

  assign avs_readdata_o = rdata_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      misc6_r     <= `BAP_RST_BYTE;
      force_ctl_r <= `BAP_RST_BYTE;
      act_mask_r  <= `BAP_RST_BYTE;
      smi_en_r    <= `BAP_RST_BYTE;
      s2s_tmr_r   <= `BAP_RST_BYTE;
      ctl3_r      <= `BAP_RST_BYTE;
    end
    else if (wr_en && avs_address_i[1:0] == 2'h0)
    begin
      case (idx)
        `BAP_IDX_MISC6:     misc6_r     <= avs_writedata_i[7:0];
        `BAP_IDX_FORCE_CTL: force_ctl_r <= avs_writedata_i[7:0];
        `BAP_IDX_ACT_MASK:  act_mask_r  <= avs_writedata_i[7:0];
        `BAP_IDX_SMI_EN:    smi_en_r    <= avs_writedata_i[7:0];
        `BAP_IDX_S2S_TMR:   s2s_tmr_r   <= avs_writedata_i[7:0];
        `BAP_IDX_PMU_CTL3:  ctl3_r      <= avs_writedata_i[7:0];
        default:            ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // forced descent and step decode
  // ----------------------------------------------------------------
  assign run_mode = (mode_r == bap_pkg::PM_HIGH) | (mode_r == bap_pkg::PM_LOW)
                    | (mode_r == bap_pkg::PM_DOZE);
  // the real pin cancels forcing, the soft power bit does not
  assign force_on = bl_low & ~ext_on & ~force_ctl_r[`BAP_BIT_FORCE_DIS]; // R2 R8
  assign pause = ((mode_r == bap_pkg::PM_LOW) & smi_en_r[`BAP_BIT_EN_LOW_DOZE])
               | ((mode_r == bap_pkg::PM_DOZE) & smi_en_r[`BAP_BIT_EN_DOZE_SLP])
               | ((mode_r == bap_pkg::PM_SLEEP) & smi_en_r[`BAP_BIT_EN_SLP_SUS]); // R5
  assign force_step = (force_on & ~pause & (run_mode | (mode_r == bap_pkg::PM_SLEEP)))
                    | ((mode_r == bap_pkg::PM_SLEEP) & bl_low & ~ext_on); // R3 R6
  assign busy = resume_pend_r | wake_pend_r;

  always_comb
  begin
    case (mode_r)
      bap_pkg::PM_HIGH:  step_mode = bap_pkg::PM_LOW;
      bap_pkg::PM_LOW:   step_mode = bap_pkg::PM_DOZE;
      bap_pkg::PM_DOZE:  step_mode = bap_pkg::PM_SLEEP;
      bap_pkg::PM_SLEEP: step_mode = bap_pkg::PM_SUSPEND;
      bap_pkg::PM_OFF:   step_mode = bap_pkg::PM_OFF;
      default:           step_mode = bap_pkg::PM_SUSPEND;
    endcase
  end

  // ----------------------------------------------------------------
  // sleep-to-suspend timer, counted in refreshes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s2s_cnt_r <= 8'h00;
    else if (mode_r != bap_pkg::PM_SLEEP)
      s2s_cnt_r <= s2s_tmr_r;
    else if (refresh_r && s2s_cnt_r != 8'h00)
      s2s_cnt_r <= s2s_cnt_r - 8'h01;
  end

  assign s2s_exp  = (mode_r == bap_pkg::PM_SLEEP) & (s2s_cnt_r == 8'h00)
                    & (s2s_tmr_r != 8'h00) & ~temp_on_r;
  assign s2s_fire = refresh_r & s2s_exp & smi_en_r[`BAP_BIT_EN_SLP_SUS]
                    & ~busy & ~force_step & ~desc_r; // R13
  assign resume_fire = refresh_r & resume_pend_r;

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mode_r <= bap_pkg::PM_HIGH;
    else if (refresh_r)
    begin
      if (busy)
        mode_r <= bap_pkg::PM_HIGH; // R4 R11 R21
      else if (temp_on_r)
      begin
        if (susp_go_r)
          mode_r <= bap_pkg::PM_SUSPEND; // R15
      end
      else if ((desc_r && run_mode) || force_step)
        mode_r <= step_mode; // R3 R10
      else
      begin
        case (mode_r)
          bap_pkg::PM_HIGH:
            if (tmr_high_low_i && !pwr_any)
              mode_r <= bap_pkg::PM_LOW; // R7
          bap_pkg::PM_LOW:
            if (tmr_low_doze_i && !pwr_any)
              mode_r <= bap_pkg::PM_DOZE; // R7
          bap_pkg::PM_DOZE:
            if (tmr_doze_sleep_i && !pwr_any)
              mode_r <= bap_pkg::PM_SLEEP; // R7
          bap_pkg::PM_SLEEP:
            if (s2s_exp && !smi_en_r[`BAP_BIT_EN_SLP_SUS])
              mode_r <= bap_pkg::PM_SUSPEND;
          bap_pkg::PM_SUSPEND:
            if (tmr_susp_off_i)
              mode_r <= bap_pkg::PM_OFF;
          bap_pkg::PM_OFF:
            mode_r <= bap_pkg::PM_OFF;
          default:
            mode_r <= bap_pkg::PM_HIGH;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // temporary-on servicing state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      temp_on_r <= 1'b0;
      susp_go_r <= 1'b0;
    end
    else
    begin
      if (s2s_fire)
        temp_on_r <= 1'b1; // R15
      else if (refresh_r && (busy || susp_go_r))
        temp_on_r <= 1'b0;
      // a write on a refresh edge is kept unless that refresh ends temporary-on
      if (a5_wr && temp_on_r && !(refresh_r && (susp_go_r || busy)))
        susp_go_r <= 1'b1; // R15
      else if (refresh_r)
        susp_go_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // suspend/resume key and wake events
  // ----------------------------------------------------------------
  // a held edge is replayed by the source-status write
  assign key_act = (key_edge & ~temp_on_r) | (key_held_r & a5_wr); // R17

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      key_held_r    <= 1'b0;
      desc_r        <= 1'b0;
      resume_pend_r <= 1'b0;
      wake_pend_r   <= 1'b0;
    end
    else
    begin
      if (key_edge && temp_on_r)
        key_held_r <= 1'b1; // R17
      else if (a5_wr)
        key_held_r <= 1'b0;
      // suspend edge starts descent only, no request
      if (key_act && !desc_r && run_mode)
        desc_r <= 1'b1; // R10 R14 R19
      else if (refresh_r && (!run_mode || mode_r == bap_pkg::PM_DOZE || busy))
        desc_r <= 1'b0;
      if (key_act && !desc_r && !run_mode)
        resume_pend_r <= 1'b1; // R11 R19
      else if (refresh_r)
        resume_pend_r <= 1'b0;
      if (wake_event_i || act_evt)
        wake_pend_r <= 1'b1; // R4 R9
      else if (refresh_r)
        wake_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // source status and request level
  // ----------------------------------------------------------------
  always_comb
  begin
    src_set = 8'h00;
    src_set[`BAP_SRC_RESUME]  = resume_fire & smi_en_r[`BAP_BIT_EN_RESUME]; // R12
    src_set[`BAP_SRC_SLP_SUS] = s2s_fire; // R13
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      src_r <= 8'h00;
      smi_r <= 1'b0;
    end
    else
    begin
      src_r <= (a5_wr ? 8'h00 : src_r) | src_set; // R16
      smi_r <= (a2_wr ? 1'b0 : smi_r) | (|src_set); // R20
    end
  end

  assign smi_request_o = smi_r;
  assign clocks_on_o   = run_mode | temp_on_r; // R18
  assign pm_mode_o     = mode_r;
  assign temp_on_o     = temp_on_r;
  assign refresh_o     = refresh_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_smi_hold;
    smi_r && !a2_wr |=> smi_r;
  endproperty
  a_smi_hold: assert property (p_smi_hold) else $error("smi dropped"); // R20

  property p_resume_jump;
    refresh_r && resume_pend_r |=> mode_r == bap_pkg::PM_HIGH && !temp_on_r;
  endproperty
  a_resume_jump: assert property (p_resume_jump) else $error("no resume"); // R11

  property p_resume_smi;
    resume_fire && smi_en_r[0] |=> smi_r && src_r[0];
  endproperty
  a_resume_smi: assert property (p_resume_smi) else $error("no resume smi"); // R12

  property p_s2s_smi;
    s2s_fire |=> smi_r && src_r[3] && temp_on_r && mode_r == bap_pkg::PM_SLEEP;
  endproperty
  a_s2s_smi: assert property (p_s2s_smi) else $error("no s2s smi"); // R13

  property p_susp_go;
    refresh_r && temp_on_r && susp_go_r && !busy |=> mode_r == bap_pkg::PM_SUSPEND;
  endproperty
  a_susp_go: assert property (p_susp_go) else $error("no suspend"); // R15

  property p_src_clr;
    a5_wr && src_set == 8'h00 |=> src_r == 8'h00;
  endproperty
  a_src_clr: assert property (p_src_clr) else $error("source kept"); // R16

  property p_key_step;
    refresh_r && desc_r && mode_r == bap_pkg::PM_HIGH && !busy && !temp_on_r
      |=> mode_r == bap_pkg::PM_LOW;
  endproperty
  a_key_step: assert property (p_key_step) else $error("no step"); // R10

  property p_force_doze;
    refresh_r && force_on && mode_r == bap_pkg::PM_DOZE && !smi_en_r[2]
      && !busy && !temp_on_r |=> mode_r == bap_pkg::PM_SLEEP;
  endproperty
  a_force_doze: assert property (p_force_doze) else $error("no force"); // R3

  property p_sleep_bl;
    refresh_r && mode_r == bap_pkg::PM_SLEEP && bl_low && !ext_on && !busy
      && !temp_on_r |=> mode_r == bap_pkg::PM_SUSPEND;
  endproperty
  a_sleep_bl: assert property (p_sleep_bl) else $error("no bl suspend"); // R6

  property p_pwr_hold;
    refresh_r && mode_r == bap_pkg::PM_HIGH && pwr_any && !desc_r
      && !force_step |=> mode_r == bap_pkg::PM_HIGH;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("timer ran"); // R7

  property p_bus_wait;
    hit && !ack_r |=> !avs_waitrequest_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus stuck");

endmodule
`default_nettype wire

// ---- tb/bap_env_model.sv ----
// bap_env_model.sv: battery comparator, external power detector and key
// assumes: bench sets the request levels by non-blocking assignment
`timescale 1ns/10ps
`default_nettype none

module bap_env_model (
  input  wire logic ref_clk_i,
  input  wire logic batt_empty_i,
  input  wire logic power_on_i,
  input  wire logic key_down_i,
  output logic      battery_level_final_n_o,
  output logic      external_power_present_o,
  output logic      suspend_resume_key_o
);
  // ----------------------------------------------------------------
  // pin levels, one clock behind the requests like real detectors
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    battery_level_final_n_o  <= ~batt_empty_i;
    external_power_present_o <= power_on_i;
    suspend_resume_key_o     <= key_down_i;
  end
endmodule

`default_nettype wire

// ---- tb/test_bap_pmu.sv ----
// test_bap_pmu.sv: self-checking bench of the power manager event block
// assumes: one wait cycle per bus access, refresh every 1500 cycles
`timescale 1ns/10ps
`default_nettype none

module test_bap_pmu;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [9:0]  avs_address_i = 10'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        batt_n;
  logic        power_pin;
  logic        key_pin;
  logic        batt_empty = 1'b0;
  logic        power_on = 1'b0;
  logic        key_down = 1'b0;
  logic        wake = 1'b0;
  logic [3:0]  tmr = 4'h0;
  logic        smi_request_o;
  logic        clocks_on_o;
  logic [5:0]  pm_mode_o;
  logic        temp_on_o;
  logic        refresh_o;
  int          fails = 0;
  int          num_checks = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  bap_env_model env (
    .ref_clk_i                (ref_clk_i),
    .batt_empty_i             (batt_empty),
    .power_on_i               (power_on),
    .key_down_i               (key_down),
    .battery_level_final_n_o  (batt_n),
    .external_power_present_o (power_pin),
    .suspend_resume_key_o     (key_pin)
  );

  bap_pmu DUT (
    .ref_clk_i                (ref_clk_i),
    .reset_n_i                (reset_n_i),
    .avs_address_i            (avs_address_i),
    .avs_read_i               (avs_read_i),
    .avs_write_i              (avs_write_i),
    .avs_writedata_i          (avs_writedata_i),
    .avs_readdata_o           (avs_readdata_o),
    .avs_waitrequest_o        (avs_waitrequest_o),
    .battery_level_final_n_i  (batt_n),
    .external_power_present_i (power_pin),
    .suspend_resume_key_i     (key_pin),
    .wake_event_i             (wake),
    .tmr_high_low_i           (tmr[0]),
    .tmr_low_doze_i           (tmr[1]),
    .tmr_doze_sleep_i         (tmr[2]),
    .tmr_susp_off_i           (tmr[3]),
    .smi_request_o            (smi_request_o),
    .clocks_on_o              (clocks_on_o),
    .pm_mode_o                (pm_mode_o),
    .temp_on_o                (temp_on_o),
    .refresh_o                (refresh_o)
  );

  // ----------------------------------------------------------------
  // compares, bus cycles and pacing
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_mode(input logic [5:0] exp);
    num_checks++;
    if (pm_mode_o !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: mode %h expected %h", $time, pm_mode_o, exp);
    end
  endtask

  task automatic bus_op(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
    @(posedge ref_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, wd};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    // hold until waitrequest is sampled low at a rising edge; the watchdog bounds it
    do
    begin
      @(posedge ref_clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus_op(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus_op(1'b0, idx, 8'h00, x);
    chk_val(x, exp, "read data");
  endtask

  // returns once the mode update of the next refresh has settled
  task automatic wait_refresh();
    do
    begin
      @(negedge ref_clk_i);
    end
    while (refresh_o !== 1'b1);
    @(negedge ref_clk_i);
  endtask

  task automatic press_key();
    @(posedge ref_clk_i);
    key_down <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    key_down <= 1'b0;
  endtask

  task automatic pulse_wake();
    @(posedge ref_clk_i);
    wake <= 1'b1;
    @(posedge ref_clk_i);
    wake <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset();
    chk_mode(bap_pkg::PM_HIGH);
    chk_val({31'h0, smi_request_o}, 32'h1 - 32'h1, "smi after reset");
    chk_val({31'h0, clocks_on_o}, 32'h1, "clocks after reset");
    rd_chk(`BAP_IDX_FORCE_CTL, 32'h0);
    rd_chk(`BAP_IDX_SMI_EN, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(`BAP_IDX_REQ_CLR, 32'h0);
    wr(`BAP_IDX_FORCE_CTL, 8'h80);
    rd_chk(`BAP_IDX_FORCE_CTL, 32'h80);
  endtask

  task automatic sc_timers();
    @(posedge ref_clk_i);
    power_on <= 1'b1;
    tmr      <= 4'h1;
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
    @(posedge ref_clk_i);
    power_on <= 1'b0;
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    @(posedge ref_clk_i);
    tmr <= 4'h0;
    pulse_wake();
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
  endtask

  task automatic sc_key_suspend();
    wr(`BAP_IDX_SMI_EN, 8'h01);
    @(posedge ref_clk_i);
    batt_empty <= 1'b1;
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
    press_key();
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    press_key();
    wait_refresh();
    chk_mode(bap_pkg::PM_DOZE);
    wait_refresh();
    chk_mode(bap_pkg::PM_SLEEP);
    chk_val({31'h0, smi_request_o}, 32'h0, "smi on suspend key");
    wait_refresh();
    chk_mode(bap_pkg::PM_SUSPEND);
  endtask

  task automatic sc_resume();
    @(posedge ref_clk_i);
    batt_empty <= 1'b0;
    press_key();
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
    chk_val({31'h0, smi_request_o}, 32'h1, "resume smi");
    chk_val({31'h0, temp_on_o}, 32'h0, "no temp-on on resume");
    rd_chk(`BAP_IDX_SRC_STS, 32'h01);
    wr(`BAP_IDX_REQ_CLR, 8'h5A);
    chk_val({31'h0, smi_request_o}, 32'h0, "smi cleared");
    rd_chk(`BAP_IDX_SRC_STS, 32'h01);
    wr(`BAP_IDX_SRC_STS, 8'hFF);
    rd_chk(`BAP_IDX_SRC_STS, 32'h00);
    wr(`BAP_IDX_S2S_TMR, 8'h01);
    wr(`BAP_IDX_SMI_EN, 8'h09);
    press_key();
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    repeat (2) wait_refresh();
    chk_mode(bap_pkg::PM_SLEEP);
  endtask

  task automatic sc_s2s();
    for (int i = 0; i < 4 && temp_on_o !== 1'b1; i++)
      wait_refresh();
    chk_val({31'h0, temp_on_o}, 32'h1, "temp-on entered");
    chk_val({31'h0, smi_request_o}, 32'h1, "timer smi");
    chk_val({31'h0, clocks_on_o}, 32'h1, "clocks in temp-on");
    rd_chk(`BAP_IDX_MODE_STS, 32'h08);
    rd_chk(`BAP_IDX_SRC_STS, 32'h08);
    press_key();
    wait_refresh();
    chk_mode(bap_pkg::PM_SLEEP);
    wr(`BAP_IDX_REQ_CLR, 8'h00);
    wr(`BAP_IDX_SRC_STS, 8'h00);
    repeat (2) wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
    chk_val({31'h0, temp_on_o}, 32'h0, "temp-on left");
    wr(`BAP_IDX_REQ_CLR, 8'h00);
    wr(`BAP_IDX_SRC_STS, 8'h00);
    // second suspend with no held key: the write leads into Suspend
    press_key();
    repeat (5) wait_refresh();
    chk_val({31'h0, temp_on_o}, 32'h1, "temp-on again");
    wr(`BAP_IDX_REQ_CLR, 8'h00);
    wr(`BAP_IDX_SRC_STS, 8'h00);
    wait_refresh();
    chk_mode(bap_pkg::PM_SUSPEND);
    pulse_wake();
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
  endtask

  task automatic sc_forced();
    wr(`BAP_IDX_SMI_EN, 8'h00);
    wr(`BAP_IDX_FORCE_CTL, 8'h00);
    wr(`BAP_IDX_MISC6, 8'h20);
    @(posedge ref_clk_i);
    batt_empty <= 1'b1;
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    wait_refresh();
    chk_mode(bap_pkg::PM_DOZE);
    wait_refresh();
    chk_mode(bap_pkg::PM_SLEEP);
    wait_refresh();
    chk_mode(bap_pkg::PM_SUSPEND);
    wait_refresh();
    chk_mode(bap_pkg::PM_SUSPEND);
    chk_val({31'h0, smi_request_o}, 32'h0, "no battery smi");
    pulse_wake();
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    wr(`BAP_IDX_SMI_EN, 8'h02);
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    wr(`BAP_IDX_SMI_EN, 8'h00);
    @(posedge ref_clk_i);
    power_on <= 1'b1;
    wait_refresh();
    chk_mode(bap_pkg::PM_LOW);
    wr(`BAP_IDX_PMU_CTL3, 8'h10);
    wr(`BAP_IDX_MISC6, 8'h00);
    @(posedge ref_clk_i);
    power_on <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    power_on <= 1'b1;
    wait_refresh();
    chk_mode(bap_pkg::PM_HIGH);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    sc_reset();
    sc_timers();
    sc_key_suspend();
    sc_resume();
    sc_s2s();
    sc_forced();
    report_and_stop();
  end

  // about 34 refreshes are needed; this leaves three quarters as much again
  initial
  begin
    repeat (90000) @(posedge ref_clk_i);
    fails++;
    report_and_stop();
  end
endmodule

`default_nettype wire
